// ===== verilog/mwc_map.svh
`ifndef MWC_MAP_SVH
`define MWC_MAP_SVH

// Register offsets on the serial register port
`define MWC_OFS_EVT_CFG_B   8'h34
`define MWC_OFS_EVT_SRC_B   8'h35
`define MWC_OFS_THRESH_B    8'h36
`define MWC_OFS_DURATION_B  8'h37
`define MWC_OFS_TAP_CFG     8'h38

// Field positions, event configuration and tap configuration
`define MWC_BIT_AND_OR      7
`define MWC_BIT_LATCH       6
`define MWC_BIT_RES_1       5
`define MWC_BIT_RES_2       4
`define MWC_BIT_Y_HIGH      3
`define MWC_BIT_Y_LOW       2
`define MWC_BIT_X_HIGH      1
`define MWC_BIT_X_LOW       0

// Field positions, event source register
`define MWC_BIT_IRQ_ACTIVE  6

// Field positions, threshold register
`define MWC_BIT_DECR_MODE   7
`define MWC_THR_MSB         6

// Writable masks: reserved and unused bits always read zero
`define MWC_MASK_EVT_CFG    8'hCF
`define MWC_MASK_TAP_CFG    8'h4F

// Reset values
`define MWC_RST_REG         8'h00

// Pad routing codes
`define MWC_ROUTE_WAKE_B    3'h2
`define MWC_ROUTE_TAP       3'h7

// Duration step per sample, in microseconds, for each sample rate
`define MWC_STEP_US_400HZ   2500
`define MWC_STEP_US_100HZ   10000

`endif

// ===== verilog/mwc_pkg.sv
package mwc_pkg;

  // Click detector pulses, one per axis and kind
  typedef struct packed {
    logic double_y;
    logic single_y;
    logic double_x;
    logic single_x;
  } mwc_tap_t;

  // Register port request from the serial interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mwc_reg_req_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] evt_cfg;
    logic [7:0] evt_src;
    logic [7:0] thresh;
    logic [7:0] duration;
    logic [7:0] tap_cfg;
    logic [7:0] dur_cnt;
    logic [7:0] rdata;
    logic       wake_irq;
    logic       tap_irq;
    logic       pad_irq;
  } mwc_state_t;

endpackage : mwc_pkg

// ===== verilog/mwc_wake_tap_irq.sv
`timescale 1ns/100ps
`include "mwc_map.svh"

module mwc_wake_tap_irq #(
  parameter int ACC_W = 8                // Width of one axis sample
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire mwc_pkg::mwc_reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  input  wire logic                  sample_tick,
  input  wire logic [ACC_W-1:0]      accel_x,
  input  wire logic [ACC_W-1:0]      accel_y,
  input  wire mwc_pkg::mwc_tap_t     tap_event,
  input  wire logic                  tap_source_read,
  input  wire logic [2:0]            pad_b_route_code,
  output logic                       second_motion_irq,
  output logic                       tap_irq,
  output logic                       pad_b_irq
);
  import mwc_pkg::*;

  // Threshold compare needs at least the seven threshold bits plus sign
  initial begin
    if (ACC_W < 8) begin
      $error("mwc_wake_tap_irq: ACC_W must be at least 8");
    end
  end

  // Magnitude of a signed sample; the most negative code saturates
  function automatic logic [ACC_W-1:0] mag_of(input logic [ACC_W-1:0] s);
    logic [ACC_W-1:0] neg;
    neg = '0;
    if (s[ACC_W-1]) begin
      neg = ~s + {{(ACC_W-1){1'b0}}, 1'b1};
      if (neg[ACC_W-1]) begin
        neg = {1'b0, {(ACC_W-1){1'b1}}};
      end
      mag_of = neg;
    end else begin
      mag_of = s;
    end
  endfunction : mag_of

  mwc_state_t       st_q;               // Registered state
  mwc_state_t       st_d;               // Next state
  logic [ACC_W-1:0] thr_ext;            // Threshold widened to sample
  logic [ACC_W-1:0] mag_x;              // X axis magnitude
  logic [ACC_W-1:0] mag_y;              // Y axis magnitude
  logic [3:0]       raw_hit;            // Y high, Y low, X high, X low
  logic [3:0]       enables;            // Enabled event mask
  logic [3:0]       hit_en;             // Raw hits under their enables
  logic             cond;               // Combined event condition
  logic             qualified;          // Condition held long enough
  logic             latch_on;           // Wake latch mode
  logic             src_read;           // Source register read strobe
  logic             frozen;             // Duration counter held
  logic [3:0]       tap_hit;            // Enabled click pulses
  logic             tap_any;            // Any enabled click this cycle

  // Outputs come straight from state flip-flops
  assign reg_rdata         = st_q.rdata;
  assign second_motion_irq = st_q.wake_irq;
  assign tap_irq           = st_q.tap_irq;
  assign pad_b_irq         = st_q.pad_irq;

  // Event detection against the threshold, magnitude based
  always_comb begin
    thr_ext  = {{(ACC_W-7){1'b0}}, st_q.thresh[`MWC_THR_MSB:0]};
    mag_x    = mag_of(accel_x);
    mag_y    = mag_of(accel_y);
    // High events fire strictly above, low events strictly below
    raw_hit[3] = (mag_y > thr_ext);
    raw_hit[2] = (mag_y < thr_ext);
    raw_hit[1] = (mag_x > thr_ext);
    raw_hit[0] = (mag_x < thr_ext);
    enables  = st_q.evt_cfg[`MWC_BIT_Y_HIGH:`MWC_BIT_X_LOW];
    hit_en   = raw_hit & enables;
    // AND with no enable set never fires, so an idle block stays quiet
    if (st_q.evt_cfg[`MWC_BIT_AND_OR]) begin
      cond = (enables != 4'h0) && (hit_en == enables);
    end else begin
      cond = (hit_en != 4'h0);
    end
  end

  // Next-state logic: registers, duration counter, source, taps, pad
  always_comb begin
    st_d      = st_q;
    latch_on  = st_q.evt_cfg[`MWC_BIT_LATCH];
    src_read  = reg_req.rd && (reg_req.addr == `MWC_OFS_EVT_SRC_B);
    // Frozen while a latched event waits for the host
    frozen    = latch_on && st_q.evt_src[`MWC_BIT_IRQ_ACTIVE];
    qualified = cond && (st_q.dur_cnt >= st_q.duration);
    tap_hit   = {tap_event.double_y, tap_event.single_y,
                 tap_event.double_x, tap_event.single_x} &
                st_q.tap_cfg[3:0];
    // Single and double share the output when both are enabled
    tap_any   = (tap_hit != 4'h0);

    // Register writes; the source register has no write path
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `MWC_OFS_EVT_CFG_B: begin
          // Reserved bits forced to zero whatever the host sends
          st_d.evt_cfg = reg_req.wdata & `MWC_MASK_EVT_CFG;
        end
        `MWC_OFS_THRESH_B: begin
          st_d.thresh = reg_req.wdata;
        end
        `MWC_OFS_DURATION_B: begin
          st_d.duration = reg_req.wdata;
        end
        `MWC_OFS_TAP_CFG: begin
          st_d.tap_cfg = reg_req.wdata & `MWC_MASK_TAP_CFG;
        end
        default: begin
          // Source and unmapped addresses keep their contents
          st_d.evt_cfg = st_q.evt_cfg;
        end
      endcase
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `MWC_OFS_EVT_CFG_B:  st_d.rdata = st_q.evt_cfg;
        `MWC_OFS_EVT_SRC_B:  st_d.rdata = st_q.evt_src;
        `MWC_OFS_THRESH_B:   st_d.rdata = st_q.thresh;
        `MWC_OFS_DURATION_B: st_d.rdata = st_q.duration;
        `MWC_OFS_TAP_CFG:    st_d.rdata = st_q.tap_cfg;
        default:             st_d.rdata = `MWC_RST_REG;
      endcase
    end

    // Source read empties the register and drops the interrupt, unless a sample tick in the same cycle brings a qualified event
    if (src_read) begin
      st_d.evt_src = `MWC_RST_REG;
    end

    // Duration counter runs only on sample ticks, counting samples
    // so the step is one sample period at whatever rate is chosen
    if (sample_tick && !frozen) begin
      if (cond) begin
        // Saturate at the programmed duration, no wrap
        if (st_q.dur_cnt < st_q.duration) begin
          st_d.dur_cnt = st_q.dur_cnt + 8'h01;
        end
      end else if (st_q.thresh[`MWC_BIT_DECR_MODE]) begin
        // Decrement mode lets brief dropouts not lose the history
        if (st_q.dur_cnt != 8'h00) begin
          st_d.dur_cnt = st_q.dur_cnt - 8'h01;
        end
      end else begin
        st_d.dur_cnt = 8'h00;
      end
    end

    // Source capture on each sample
    if (sample_tick) begin
      if (latch_on) begin
        // Latched: a read in the same cycle as a new event loses,
        // so the host never misses a request that lands on its read
        if (qualified && (!st_q.evt_src[`MWC_BIT_IRQ_ACTIVE] ||
                          src_read)) begin
          st_d.evt_src = {1'b0, 1'b1, 2'b00, hit_en};
        end else if (qualified) begin
          st_d.evt_src = st_q.evt_src;
        end
      end else begin
        // Not latched: source follows the qualified condition
        if (qualified) begin
          st_d.evt_src = {1'b0, 1'b1, 2'b00, hit_en};
        end else begin
          st_d.evt_src = `MWC_RST_REG;
        end
      end
    end

    // Wake interrupt mirrors the active flag of the next source value
    st_d.wake_irq = st_d.evt_src[`MWC_BIT_IRQ_ACTIVE];

    // Click request: latched holds until the tap source is read
    if (st_q.tap_cfg[`MWC_BIT_LATCH]) begin
      if (tap_any) begin
        st_d.tap_irq = 1'b1;
      end else if (tap_source_read) begin
        st_d.tap_irq = 1'b0;
      end
    end else begin
      st_d.tap_irq = tap_any;
    end

    // Pad routing of the two requests
    unique case (pad_b_route_code)
      `MWC_ROUTE_WAKE_B: st_d.pad_irq = st_d.wake_irq;
      `MWC_ROUTE_TAP:    st_d.pad_irq = st_d.tap_irq;
      default:           st_d.pad_irq = 1'b0;
    endcase
  end

  // State register; everything starts disabled and cleared
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q.evt_cfg  <= `MWC_RST_REG;
      st_q.evt_src  <= `MWC_RST_REG;
      st_q.thresh   <= `MWC_RST_REG;
      st_q.duration <= `MWC_RST_REG;
      st_q.tap_cfg  <= `MWC_RST_REG;
      st_q.dur_cnt  <= `MWC_RST_REG;
      st_q.rdata    <= `MWC_RST_REG;
      st_q.wake_irq <= 1'b0;
      st_q.tap_irq  <= 1'b0;
      st_q.pad_irq  <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : mwc_wake_tap_irq

// ===== test/mwc_host.sv
`timescale 1ns/100ps
`include "mwc_map.svh"

// Host side of the register port, one byte per request
module mwc_host
  import mwc_pkg::*;
(
  input  wire logic clk_sys,           // System clock
  output mwc_reg_req_t reg_req         // Request towards the block
);
  initial reg_req = '0;

  // Write strobe for one cycle, released on the next falling edge
  task automatic write(logic [7:0] a, logic [7:0] v);
    @(negedge clk_sys);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    // Configuration bits 5 and 4 always sent as zero; tap configuration bit 7 is passed through
    reg_req.wdata = (a == 8'h34 || a == 8'h38) ? v & 8'hCF : v;
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
    reg_req.wdata = ~reg_req.wdata;    // Stale data never looks valid
  endtask : write

  // Read strobe for one cycle
  task automatic read(logic [7:0] a);
    @(negedge clk_sys);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge clk_sys);
    reg_req.rd = 1'b0;
    reg_req.addr = ~a;
  endtask : read
endmodule : mwc_host

// ===== test/mwc_wake_tap_irq_chk.sv
`timescale 1ns/100ps

// Port-level checks of the wake and tap request block
module mwc_chk
  import mwc_pkg::*;
#(
  parameter int ACC_W = 8              // Axis sample width
) (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire mwc_reg_req_t       reg_req,
  input wire logic [7:0]         reg_rdata,
  input wire logic               sample_tick,
  input wire logic [ACC_W-1:0]   accel_x,
  input wire logic [ACC_W-1:0]   accel_y,
  input wire mwc_tap_t           tap_event,
  input wire logic               tap_source_read,
  input wire logic [2:0]         pad_b_route_code,
  input wire logic               second_motion_irq,
  input wire logic               tap_irq,
  input wire logic               pad_b_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Read of the wake source register
  wire src_rd = reg_req.rd && reg_req.addr == 8'h35;

  rdata_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_req.rd && reg_req.addr > 8'h38
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  src_active_a: assert property (src_rd |=>
    reg_rdata[6] == $past(second_motion_irq) && (reg_rdata & 8'hB0) == 8'h00)
    else $error("source active flag disagrees with request");
  read_clears_a: assert property (src_rd && !sample_tick
    |=> !second_motion_irq) else $error("source read left request up");
  wake_on_tick_a: assert property ($rose(second_motion_irq)
    |-> $past(sample_tick)) else $error("request rose without a sample");
  wake_steady_a: assert property (!sample_tick && !src_rd
    |=> $stable(second_motion_irq)) else $error("request moved while idle");
  pad_route_a: assert property (pad_b_irq ==
    ($past(pad_b_route_code) == 3'h2 ? second_motion_irq :
     $past(pad_b_route_code) == 3'h7 ? tap_irq : 1'b0))
    else $error("pad carries the wrong request");
  tap_cause_a: assert property ($rose(tap_irq) |-> $past(|tap_event))
    else $error("click request without a click");
endmodule : mwc_chk

// ===== test/test_mwc_wake_tap_irq.sv
`timescale 1ns/100ps

// Bench for the second wake and tap request block
module test_mwc_wake_tap_irq;
  import mwc_pkg::*;
  logic         clk_sys = 1'b0;        // 50 MHz clock
  logic         resetn = 1'b0;         // Reset, active low
  mwc_reg_req_t reg_req;               // Driven by the host model
  logic [7:0]   reg_rdata;
  logic         sample_tick = 1'b0;
  logic [7:0]   accel_x = 8'h00;
  logic [7:0]   accel_y = 8'h00;
  mwc_tap_t     tap_event = '0;
  logic         tap_source_read = 1'b0;
  logic [2:0]   pad_b_route_code = 3'h0;
  logic         second_motion_irq, tap_irq, pad_b_irq;
  logic         rd_d = 1'b0;           // A read was taken at last edge
  logic [7:0]   exp_q[$];              // Expected read data, oldest first
  int           err_count = 0;
  int           compares = 0;
  int           x, y, e;
  wire [7:0]    irqs = {5'h0, pad_b_irq, tap_irq, second_motion_irq};

  always #10 clk_sys = ~clk_sys;

  mwc_host mwc_host_i (.clk_sys, .reg_req);
  mwc_wake_tap_irq mwc_wake_tap_irq_i (.clk_sys, .resetn, .reg_req,
    .reg_rdata, .sample_tick, .accel_x, .accel_y, .tap_event,
    .tap_source_read, .pad_b_route_code, .second_motion_irq, .tap_irq,
    .pad_b_irq);

  task automatic check(string what, logic [7:0] seen, logic [7:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic wr(logic [7:0] a, logic [7:0] v);
    mwc_host_i.write(a, v);
  endtask : wr

  // Note the expectation first, the watcher pops it
  task automatic rd(logic [7:0] a, logic [7:0] v);
    exp_q.push_back(v);
    mwc_host_i.read(a);
  endtask : rd

  // One output sample with the given axis values
  task automatic tick(int ax, int ay);
    @(negedge clk_sys);
    sample_tick = 1'b1;
    accel_x = ax[7:0];
    accel_y = ay[7:0];
    @(negedge clk_sys);
    sample_tick = 1'b0;
  endtask : tick

  task automatic tap(logic [3:0] v);
    @(negedge clk_sys);
    tap_event = v;
    @(negedge clk_sys);
    tap_event = '0;
  endtask : tap

  function automatic int ab(int v);
    return v < 0 ? -v : v;
  endfunction : ab

  // Read data answers one edge after the read is taken
  always @(posedge clk_sys) rd_d <= reg_req.rd;
  always @(negedge clk_sys) begin
    if (rd_d && exp_q.size() > 0)
      check("read data", reg_rdata, exp_q.pop_front());
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h1b77_694d));
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    for (int a = 8'h34; a <= 8'h38; a++) rd(a[7:0], 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h34, 8'hFF);
    wr(8'h38, 8'hFF);
    wr(8'h35, 8'hFF);
    wr(8'h36, 8'h7F);
    wr(8'h37, 8'hFF);
    rd(8'h34, 8'hCF);
    rd(8'h38, 8'h4F);
    rd(8'h35, 8'h00);
    rd(8'h36, 8'h7F);
    rd(8'h37, 8'hFF);
    // All four events ORed, threshold 20, no latch
    wr(8'h34, 8'h0F);
    wr(8'h36, 8'h14);
    wr(8'h37, 8'h00);
    wr(8'h38, 8'h00);
    repeat (24) begin
      x = int'($urandom_range(80)) - 40;
      y = int'($urandom_range(80)) - 40;
      e = {ab(y) > 20, ab(y) < 20, ab(x) > 20, ab(x) < 20};
      tick(x, y);
      check("or irq", irqs, e != 0 ? 8'h01 : 8'h00);
      rd(8'h35, e != 0 ? 8'h40 | e[7:0] : 8'h00);
    end
    // Both high events ANDed
    wr(8'h34, 8'h8A);
    tick(30, 5);
    check("and one", irqs, 8'h00);
    tick(-30, 30);
    rd(8'h35, 8'h4A);
    // Latched with two samples of duration
    wr(8'h37, 8'h02);
    wr(8'h34, 8'h42);
    repeat (2) tick(30, 0);
    check("early", irqs, 8'h00);
    tick(30, 0);
    tick(0, 0);
    check("held", irqs, 8'h01);
    rd(8'h35, 8'h42);
    check("cleared", irqs, 8'h00);
    tick(30, 0);
    check("frozen count", irqs, 8'h01);
    rd(8'h35, 8'h42);
    // Quiet sample resets or decrements the count
    wr(8'h34, 8'h02);
    for (int m = 0; m < 2; m++) begin
      wr(8'h36, m ? 8'h94 : 8'h14);
      repeat (3) tick(30, 0);
      tick(0, 0);
      repeat (2) tick(30, 0);
      check("count mode", irqs, m ? 8'h01 : 8'h00);
    end
    for (int c = 0; c < 8; c++) begin
      @(negedge clk_sys);
      pad_b_route_code = c[2:0];
      @(negedge clk_sys);
      check("pad", irqs, c == 2 ? 8'h05 : 8'h01);
    end
    // Each click kind alone, others must stay silent
    for (int b = 0; b < 4; b++) begin
      wr(8'h38, 8'h01 << b);
      tap(4'h1 << b);
      check("click on", irqs, 8'h07);
      tap(~(4'h1 << b));
      check("click off", irqs, 8'h01);
    end
    wr(8'h38, 8'h4F);
    tap(4'h4);
    repeat (3) @(negedge clk_sys);
    check("click held", irqs, 8'h07);
    tap_source_read = 1'b1;
    @(negedge clk_sys);
    tap_source_read = 1'b0;
    check("click read", irqs, 8'h01);
    print_verdict();
  end
endmodule : test_mwc_wake_tap_irq

bind mwc_wake_tap_irq mwc_chk #(.ACC_W(ACC_W)) mwc_chk_i (.clk_sys, .resetn,
  .reg_req, .reg_rdata, .sample_tick, .accel_x, .accel_y, .tap_event,
  .tap_source_read, .pad_b_route_code, .second_motion_irq, .tap_irq,
  .pad_b_irq);
